//--- pkg/scrb_pkg.sv
// Shared constants and carrier types for the sensor control register bank.
// Assumes a single 20 MHz clock domain; no other package is needed.
package scrb_pkg;

   // Register addresses, two bytes, MSB sent first on the bus
   localparam logic [15:0] ADDR_STANDBY = 16'h3000;
   localparam logic [15:0] ADDR_HOLD = 16'h3001;
   localparam logic [15:0] ADDR_SYNC_RUN = 16'h3002;
   localparam logic [15:0] ADDR_SYNC_ROLE = 16'h3003;
   localparam logic [15:0] ADDR_HBIN = 16'h3020;
   localparam logic [15:0] ADDR_VBIN = 16'h3021;
   localparam logic [15:0] ADDR_CBIN = 16'h3022;
   localparam logic [15:0] ADDR_FLIP = 16'h3030;
   localparam logic [15:0] ADDR_CONV_W = 16'h3031;
   localparam logic [15:0] ADDR_OUT_W = 16'h3032;
   localparam logic [15:0] ADDR_RATE = 16'h3033;
   localparam logic [15:0] ADDR_GAIN_LO = 16'h3090;
   localparam logic [15:0] ADDR_GAIN_HI = 16'h3091;

   // Whole register space: 17 pages of 256 bytes
   localparam logic [15:0] SPACE_BASE = 16'h3000;
   localparam logic [15:0] SPACE_TOP = 16'h40ff;
   localparam int SPACE_DEPTH = 4352;
   localparam int SPACE_AW = 13;

   // Reset values of the named fields
   localparam logic RST_STANDBY = 1'b1;
   localparam logic RST_HOLD = 1'b0;
   localparam logic RST_SYNC_RUN_N = 1'b1;
   localparam logic RST_SYNC_ROLE_N = 1'b0;
   localparam logic RST_HBIN = 1'b0;
   localparam logic RST_VBIN = 1'b0;
   localparam logic [1:0] RST_CBIN = 2'h0;
   localparam logic [1:0] RST_FLIP = 2'h0;
   localparam logic [1:0] RST_CONV_W = 2'h1;
   localparam logic RST_OUT_W = 1'b1;
   localparam logic [3:0] RST_RATE = 4'h4;
   localparam logic [8:0] RST_GAIN = 9'h000;

   // 7-bit bus addresses chosen by the two select straps {sel1, sel0}
   localparam logic [6:0] BUS_ADDR_00 = 7'h1a;
   localparam logic [6:0] BUS_ADDR_01 = 7'h10;
   localparam logic [6:0] BUS_ADDR_10 = 7'h36;
   localparam logic [6:0] BUS_ADDR_11 = 7'h37;

   // Serial byte framing
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] TX_LAST_BIT = 4'h7;

   // Byte engine states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_RX_ACK = 3'b010,
      ST_TX = 3'b011,
      ST_TX_ACK = 3'b100
   } scrb_state_e;

   // Which byte of a transfer is expected next
   typedef enum logic [1:0] {
      PH_DEV = 2'b00,
      PH_PTR_HI = 2'b01,
      PH_PTR_LO = 2'b10,
      PH_DATA = 2'b11
   } scrb_phase_e;

   // Bus line events, one-cycle pulses plus the sampled data level
   typedef struct packed {
      logic start;
      logic stop;
      logic scl_rise;
      logic scl_fall;
      logic sda;
   } scrb_cond_s;

   // Settings that take effect on leaving standby
   typedef struct packed {
      logic sync_role_n;
      logic hbin;
      logic vbin;
      logic [1:0] cbin;
      logic [1:0] conv_w;
      logic out_w;
      logic [3:0] rate;
   } scrb_sb_s;

   // Settings that take effect at a frame boundary
   typedef struct packed {
      logic [1:0] flip;
      logic [8:0] gain;
   } scrb_fr_s;

   localparam scrb_sb_s RST_SB = '{RST_SYNC_ROLE_N, RST_HBIN, RST_VBIN, RST_CBIN,
                                   RST_CONV_W, RST_OUT_W, RST_RATE};
   localparam scrb_fr_s RST_FR = '{RST_FLIP, RST_GAIN};

endpackage

//--- hw/scrb_bus_cond.sv
// Bus line event detector: start, stop and clock edges.
// Assumes SCL and SDA are already synchronous to CLOCK.
`timescale 1ns/1ps
module scrb_bus_cond
   import scrb_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CE,
   // Bus lines
   input wire logic SCL,
   input wire logic SDA,
   // Events
   output scrb_cond_s COND
);

   typedef struct packed {
      logic scl_q;   // Previous clock level
      logic sda_q;   // Previous data level
   } scrb_bc_s;

   scrb_bc_s r_reg;   // Registered state
   scrb_bc_s r_next;  // Next state

   ////////////////////////////////////////////////////////////////////////
   // Next state: plain sampling of both lines
   always_comb begin
      r_next = r_reg;
      r_next.scl_q = SCL;
      r_next.sda_q = SDA;
   end

   // Idle bus is high on both lines
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         r_reg <= '{1'b1, 1'b1};
      end else if (CE) begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data edges with clock high are start and stop; gated by CE so a frozen
   // block never sees an event twice
   always_comb begin
      COND.start = CE & r_reg.scl_q & SCL & r_reg.sda_q & ~SDA;
      COND.stop = CE & r_reg.scl_q & SCL & ~r_reg.sda_q & SDA;
      COND.scl_rise = CE & ~r_reg.scl_q & SCL;
      COND.scl_fall = CE & r_reg.scl_q & ~SCL;
      COND.sda = SDA;
   end

endmodule

//--- hw/scrb_update_stage.sv
// Active copy of a group of settings, loaded from its write buffer on a
// strobe. Assumes the buffer is held stable by the caller.
`timescale 1ns/1ps
module scrb_update_stage
   import scrb_pkg::*;
#(
   parameter int W = 8,
   parameter logic [W-1:0] INIT = '0
)
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CE,
   // Buffer side
   input wire logic LOAD,
   input wire logic [W-1:0] D,
   // Active side
   output logic [W-1:0] Q
);

   typedef struct packed {
      logic [W-1:0] active;  // Value in force
   } scrb_us_s;

   scrb_us_s r_reg;   // Registered state
   scrb_us_s r_next;  // Next state

   ////////////////////////////////////////////////////////////////////////
   // Take the buffer only on the strobe
   always_comb begin
      r_next = r_reg;
      if (LOAD) begin
         r_next.active = D;
      end
   end

   // Reset to the group's power-up values
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         r_reg.active <= INIT;
      end else if (CE) begin
         r_reg <= r_next;
      end
   end

   assign Q = r_reg.active;

endmodule

//--- hw/scrb_top.sv
// Sensor control register bank: serial slave, index, register space and
// the three update classes (immediate, standby release, frame boundary).
// Assumes SCL/SDA are synchronous to CLOCK and SDA is open drain outside.
//
// Functional notes
// - Read address: ack, then drive byte at index
// - Master ack advances index, next byte driven
// - Write: device, pointer, data stored at index
// - Each write byte acked, index increments
// - 4352 bytes, pages 30h to 40h
// - Immediate registers act on write completion
// - Standby registers act on standby release
// - Frame registers act at frame boundary
// - Gain reaches output one frame later
// - 3000h bit0 standby, reset 1, immediate
// - Hold bit blocks frame-class loads; the gain lag stage still steps
// - 3002h bit0 stops sync generation, reset 1
// - 3003h bit0 slave role, standby class
// - Binning selects at 3020h-3022h, standby class
// - 3030h flip bits, frame class
// - 3031h conversion width, reset 1, standby
// - 3032h output width, reset 1, standby
// - 3033h link rate, reset 4h, standby
// - Two-byte pointer MSB first, byte data
// - Bus address from two select straps
`timescale 1ns/1ps
module scrb_top
   import scrb_pkg::*;
(
   // Clock, reset, enable
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CE,
   // Serial bus
   input wire logic SCL,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   // Address straps
   input wire logic BUS_ADDR_SEL0,
   input wire logic BUS_ADDR_SEL1,
   // Timing from the sensor core
   input wire logic FRAME_BOUNDARY,
   // Immediate settings
   output logic STANDBY,
   output logic UPDATE_HOLD,
   output logic SYNC_RUN_N,
   // Standby-class settings
   output logic SYNC_ROLE_N,
   output logic HORIZONTAL_BINNING,
   output logic VERTICAL_BINNING,
   output logic [1:0] COMBINED_BINNING,
   output logic [1:0] CONVERSION_WIDTH,
   output logic OUTPUT_WIDTH,
   output logic [3:0] LINK_RATE,
   // Frame-class settings
   output logic HORIZONTAL_FLIP,
   output logic VERTICAL_FLIP,
   output logic [8:0] GAIN
);

   typedef struct packed {
      scrb_state_e state;     // Byte engine state
      scrb_phase_e phase;     // Expected byte
      logic [3:0] bit_cnt;    // Bits moved in this byte
      logic [7:0] shift;      // Serial shift register
      logic rw;               // Read transfer addressed
      logic [7:0] ptr_hi;     // Pointer high byte in flight
      logic [15:0] index;     // Register index
      logic standby;          // Immediate: standby
      logic hold;             // Immediate: update hold
      logic sync_run_n;       // Immediate: sync generator stop
      logic stby_q;           // Standby level last cycle
      scrb_sb_s sb;           // Standby-class write buffer
      scrb_fr_s fr;           // Frame-class write buffer
   } scrb_top_s;

   scrb_top_s r_reg;   // Registered state
   scrb_top_s r_next;  // Next state

   logic [7:0] space_mem [0:SPACE_DEPTH-1];  // Unnamed registers
   logic mem_we;                             // Space write strobe
   logic [SPACE_AW-1:0] mem_addr;            // Space write offset
   logic [7:0] mem_wd;                       // Space write data
   scrb_cond_s cond;                         // Bus events
   scrb_sb_s sb_active;                      // Standby class in force
   scrb_fr_s fr_active;                      // Frame class in force
   logic [8:0] gain_out;                     // Gain one frame behind
   logic sb_load;                            // Standby release strobe
   logic fr_load;                            // Frame update strobe

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Index inside the 4352-byte space
   function automatic logic in_space(input logic [15:0] idx);
      in_space = (idx >= SPACE_BASE) && (idx <= SPACE_TOP);
   endfunction

   // Offset of an index into the space array
   function automatic logic [SPACE_AW-1:0] space_off(input logic [15:0] idx);
      logic [15:0] d;
      d = idx - SPACE_BASE;
      space_off = d[SPACE_AW-1:0];
   endfunction

   // Strap decode
   function automatic logic [6:0] bus_address(input logic s1, input logic s0);
      case ({s1, s0})
         2'b00: bus_address = BUS_ADDR_00;
         2'b01: bus_address = BUS_ADDR_01;
         2'b10: bus_address = BUS_ADDR_10;
         default: bus_address = BUS_ADDR_11;
      endcase
   endfunction

   // Byte seen by a reader; named fields read their write buffer, fixed
   // bits read zero, outside the space reads zero
   function automatic logic [7:0] read_byte(input scrb_top_s s);
      case (s.index)
         ADDR_STANDBY: read_byte = {7'h00, s.standby};
         ADDR_HOLD: read_byte = {7'h00, s.hold};
         ADDR_SYNC_RUN: read_byte = {7'h00, s.sync_run_n};
         ADDR_SYNC_ROLE: read_byte = {7'h00, s.sb.sync_role_n};
         ADDR_HBIN: read_byte = {7'h00, s.sb.hbin};
         ADDR_VBIN: read_byte = {7'h00, s.sb.vbin};
         ADDR_CBIN: read_byte = {6'h00, s.sb.cbin};
         ADDR_FLIP: read_byte = {6'h00, s.fr.flip};
         ADDR_CONV_W: read_byte = {6'h00, s.sb.conv_w};
         ADDR_OUT_W: read_byte = {7'h00, s.sb.out_w};
         ADDR_RATE: read_byte = {4'h0, s.sb.rate};
         ADDR_GAIN_LO: read_byte = s.fr.gain[7:0];
         ADDR_GAIN_HI: read_byte = {7'h00, s.fr.gain[8]};
         default: read_byte = in_space(s.index) ? space_mem[space_off(s.index)] : 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus event detector
   scrb_bus_cond u_cond (
      .CLOCK(CLOCK),
      .RST(RST),
      .CE(CE),
      .SCL(SCL),
      .SDA(SDA_IN),
      .COND(cond)
   );

   ////////////////////////////////////////////////////////////////////////
   // Byte engine and register writes
   always_comb begin
      r_next = r_reg;
      mem_we = 1'b0;
      mem_addr = space_off(r_reg.index);
      mem_wd = r_reg.shift;
      r_next.stby_q = r_reg.standby;
      case (r_reg.state)
         // Wait for a start
         ST_IDLE: begin
         end
         // Receive one byte, MSB first
         ST_RX: begin
            if (cond.scl_rise && (r_reg.bit_cnt != BITS_PER_BYTE)) begin
               r_next.shift = {r_reg.shift[6:0], cond.sda};
               r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
            end else if (cond.scl_fall && (r_reg.bit_cnt == BITS_PER_BYTE)) begin
               r_next.state = ST_RX_ACK;
               case (r_reg.phase)
                  // Address byte: answer only our own address
                  PH_DEV: begin
                     if (r_reg.shift[7:1] != bus_address(BUS_ADDR_SEL1, BUS_ADDR_SEL0)) begin
                        r_next.state = ST_IDLE;
                     end else if (r_reg.shift[0]) begin
                        r_next.rw = 1'b1;
                        r_next.phase = PH_DATA;
                     end else begin
                        r_next.phase = PH_PTR_HI;
                     end
                  end
                  // Pointer bytes, high first
                  PH_PTR_HI: begin
                     r_next.ptr_hi = r_reg.shift;
                     r_next.phase = PH_PTR_LO;
                  end
                  PH_PTR_LO: begin
                     r_next.index = {r_reg.ptr_hi, r_reg.shift};
                     r_next.phase = PH_DATA;
                  end
                  // Data byte: store and step the index with the ack
                  default: begin
                     r_next.index = r_reg.index + 16'h0001;
                     case (r_reg.index)
                        ADDR_STANDBY: r_next.standby = r_reg.shift[0];
                        ADDR_HOLD: r_next.hold = r_reg.shift[0];
                        ADDR_SYNC_RUN: r_next.sync_run_n = r_reg.shift[0];
                        ADDR_SYNC_ROLE: r_next.sb.sync_role_n = r_reg.shift[0];
                        ADDR_HBIN: r_next.sb.hbin = r_reg.shift[0];
                        ADDR_VBIN: r_next.sb.vbin = r_reg.shift[0];
                        ADDR_CBIN: r_next.sb.cbin = r_reg.shift[1:0];
                        ADDR_FLIP: r_next.fr.flip = r_reg.shift[1:0];
                        ADDR_CONV_W: r_next.sb.conv_w = r_reg.shift[1:0];
                        ADDR_OUT_W: r_next.sb.out_w = r_reg.shift[0];
                        ADDR_RATE: r_next.sb.rate = r_reg.shift[3:0];
                        ADDR_GAIN_LO: r_next.fr.gain[7:0] = r_reg.shift;
                        ADDR_GAIN_HI: r_next.fr.gain[8] = r_reg.shift[0];
                        // Out-of-space writes are acked and dropped
                        default: mem_we = in_space(r_reg.index);
                     endcase
                  end
               endcase
            end
         end
         // Hold ack low for one bus clock
         ST_RX_ACK: begin
            if (cond.scl_fall) begin
               r_next.bit_cnt = 4'h0;
               if (r_reg.rw) begin
                  r_next.state = ST_TX;
                  r_next.shift = read_byte(r_reg);
               end else begin
                  r_next.state = ST_RX;
               end
            end
         end
         // Drive one byte, next bit on each falling clock
         ST_TX: begin
            if (cond.scl_fall) begin
               r_next.shift = {r_reg.shift[6:0], 1'b0};
               r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
               if (r_reg.bit_cnt == TX_LAST_BIT) begin
                  r_next.state = ST_TX_ACK;
               end
            end
         end
         // Master answers; either answer steps the index
         ST_TX_ACK: begin
            if (cond.scl_rise) begin
               r_next.index = r_reg.index + 16'h0001;
               if (cond.sda) begin
                  r_next.state = ST_IDLE;
               end
            end else if (cond.scl_fall) begin
               r_next.state = ST_TX;
               r_next.bit_cnt = 4'h0;
               r_next.shift = read_byte(r_reg);
            end
         end
         default: r_next.state = ST_IDLE;
      endcase
      // Start or repeated start restarts framing; stop ends any transfer
      if (cond.start) begin
         r_next.state = ST_RX;
         r_next.phase = PH_DEV;
         r_next.bit_cnt = 4'h0;
         r_next.rw = 1'b0;
      end else if (cond.stop) begin
         r_next.state = ST_IDLE;
         r_next.rw = 1'b0;
      end
   end

   // State register
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         r_reg.state <= ST_IDLE;
         r_reg.phase <= PH_DEV;
         r_reg.bit_cnt <= 4'h0;
         r_reg.shift <= 8'h00;
         r_reg.rw <= 1'b0;
         r_reg.ptr_hi <= 8'h00;
         r_reg.index <= 16'h0000;
         r_reg.standby <= RST_STANDBY;
         r_reg.hold <= RST_HOLD;
         r_reg.sync_run_n <= RST_SYNC_RUN_N;
         r_reg.stby_q <= RST_STANDBY;
         r_reg.sb <= RST_SB;
         r_reg.fr <= RST_FR;
      end else if (CE) begin
         r_reg <= r_next;
      end
   end

   // Unnamed registers; plain storage, no reset, power-up contents undefined
   always_ff @(posedge CLOCK) begin
      if (CE && mem_we) begin
         space_mem[mem_addr] <= mem_wd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Update classes
   assign sb_load = r_reg.stby_q & ~r_reg.standby;
   assign fr_load = FRAME_BOUNDARY & ~r_reg.hold;

   // Standby class: buffer is free to change while in standby
   scrb_update_stage #(.W($bits(scrb_sb_s)), .INIT(RST_SB)) u_sb (
      .CLOCK(CLOCK),
      .RST(RST),
      .CE(CE),
      .LOAD(sb_load),
      .D(r_reg.sb),
      .Q(sb_active)
   );

   // Frame class: held back while update hold is set
   scrb_update_stage #(.W($bits(scrb_fr_s)), .INIT(RST_FR)) u_fr (
      .CLOCK(CLOCK),
      .RST(RST),
      .CE(CE),
      .LOAD(fr_load),
      .D(r_reg.fr),
      .Q(fr_active)
   );

   // Gain trails the other frame settings by one boundary
   scrb_update_stage #(.W(9), .INIT(RST_GAIN)) u_gain (
      .CLOCK(CLOCK),
      .RST(RST),
      .CE(CE),
      .LOAD(FRAME_BOUNDARY),
      .D(fr_active.gain),
      .Q(gain_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs; SDA is open drain, so only a low is ever driven
   assign SDA_OUT = 1'b0;
   assign SDA_OE = (r_reg.state == ST_RX_ACK) | ((r_reg.state == ST_TX) & ~r_reg.shift[7]);
   assign STANDBY = r_reg.standby;
   assign UPDATE_HOLD = r_reg.hold;
   assign SYNC_RUN_N = r_reg.sync_run_n;
   assign SYNC_ROLE_N = sb_active.sync_role_n;
   assign HORIZONTAL_BINNING = sb_active.hbin;
   assign VERTICAL_BINNING = sb_active.vbin;
   assign COMBINED_BINNING = sb_active.cbin;
   assign CONVERSION_WIDTH = sb_active.conv_w;
   assign OUTPUT_WIDTH = sb_active.out_w;
   assign LINK_RATE = sb_active.rate;
   assign HORIZONTAL_FLIP = fr_active.flip[0];
   assign VERTICAL_FLIP = fr_active.flip[1];
   assign GAIN = gain_out;

endmodule

//--- dv/scrb_asserts.sv
// Pin-level checks on the register bank.
// Assumes binding into scrb_top; sees its ports only.
`timescale 1ns/1ps
module scrb_asserts (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   // Bus and frame timing
   input wire logic SCL,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   input wire logic FRAME_BOUNDARY,
   // Settings
   input wire logic STANDBY,
   input wire logic UPDATE_HOLD,
   input wire logic SYNC_RUN_N,
   input wire logic SYNC_ROLE_N,
   input wire logic HORIZONTAL_BINNING,
   input wire logic VERTICAL_BINNING,
   input wire logic [1:0] COMBINED_BINNING,
   input wire logic [1:0] CONVERSION_WIDTH,
   input wire logic OUTPUT_WIDTH,
   input wire logic [3:0] LINK_RATE,
   input wire logic HORIZONTAL_FLIP,
   input wire logic VERTICAL_FLIP,
   input wire logic [8:0] GAIN
);
   default clocking dclk @(posedge CLOCK); endclocking
   default disable iff (RST);
   // Standby-class group and frame-class flip bits
   wire [11:0] sb_w = {SYNC_ROLE_N, HORIZONTAL_BINNING, VERTICAL_BINNING,
      COMBINED_BINNING, CONVERSION_WIDTH, OUTPUT_WIDTH, LINK_RATE};
   wire [1:0] fr_w = {VERTICAL_FLIP, HORIZONTAL_FLIP};
   ////////////////////////////////////////////////////////////////////////
   AST_OE_EDGE: assert property ($changed(SDA_OE) |-> !SCL &&
      ($past(SCL, 2) || $past(SCL, 3) || $past(SCL, 4))) else $error("SDA moved with SCL high");
   AST_ACK_HOLD: assert property ($rose(SDA_OE) |-> SDA_OE [*6])
      else $error("Pull-down too short");
   AST_OPEN_DRAIN: assert property (SDA_OE |-> !SDA_OUT)
      else $error("SDA driven high");
   AST_IMM: assert property ($changed({STANDBY, UPDATE_HOLD, SYNC_RUN_N}) |->
      SDA_OE || $past(SDA_OE)) else $error("Immediate setting moved off ack");
   AST_SB_CHG: assert property ($changed(sb_w) |-> !STANDBY &&
      ($past(STANDBY) || $past(STANDBY, 2) || $past(STANDBY, 3))) else $error("Standby load early");
   AST_SB_KEEP: assert property (STANDBY && $past(STANDBY) |-> $stable(sb_w))
      else $error("Standby setting moved in standby");
   AST_FRAME: assert property ($changed(fr_w) |->
      !($past(UPDATE_HOLD) && $past(UPDATE_HOLD, 2)) &&
      ($past(FRAME_BOUNDARY) || $past(FRAME_BOUNDARY, 2))) else $error("Flip moved off frame");
   AST_GAIN: assert property ($changed(GAIN) |->
      $past(FRAME_BOUNDARY) || $past(FRAME_BOUNDARY, 2)) else $error("Gain moved off frame");
   // Main scenarios reached
   AST_COV_REL: cover property ($fell(STANDBY));
   AST_COV_GAIN: cover property ($changed(GAIN));
   AST_COV_FLIP: cover property ($changed(fr_w));
endmodule
bind scrb_top scrb_asserts u_chk (.*);

//--- dv/scrb_i2c_mst.sv
// Bus master model for the register bank.
// Assumes the bench resolves SDA with a pull-up; 1 on sda_m releases it.
`timescale 1ns/1ps
module scrb_i2c_mst (
   // Clock and resolved wire
   input wire logic clk,
   input wire logic sda,
   // Driven lines
   output logic scl,
   output logic sda_m
);
   // Bus idles high
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(negedge clk);
   endtask
   // One bit; SDA moves a cycle after SCL falls, never with it
   task automatic bit_io(input logic b, output logic r);
      w(1);
      sda_m = b;
      w(3);
      scl = 1'b1;
      w(4);
      r = sda;
      scl = 1'b0;
   endtask
   // Start, also serves as repeated start
   task automatic start();
      w(1);
      sda_m = 1'b1;
      w(2);
      scl = 1'b1;
      w(4);
      sda_m = 1'b0;
      w(4);
      scl = 1'b0;
   endtask
   // Stop; a repeated start or a read nack also ends a transfer
   task automatic stop();
      w(1);
      sda_m = 1'b0;
      w(2);
      scl = 1'b1;
      w(4);
      sda_m = 1'b1;
      w(4);
   endtask
   // Byte out MSB first, returns ack level
   task automatic tx(input logic [7:0] d, output logic a);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], a);
      end
      bit_io(1'b1, a);
   endtask
   // Byte in, then ack or nack
   task automatic rx(input logic nak, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(nak, r);
   endtask
endmodule

//--- dv/testbench.sv
// Self-checking bench for scrb_top through its serial slave port.
// Assumes the master model and the bound checker beside it.
`timescale 1ns/1ps
module testbench
   import scrb_pkg::*;
   ;
   logic clk, rst, fb, sel0, sel1, scl, sda_m, sda_oe, sda_out, k, ce;
   logic sb, hold, run_n, role_n, hb, vb, hf, vf, ow;
   logic [1:0] cb, cw;
   logic [3:0] lr;
   logic [8:0] gain;
   logic [6:0] dev;
   int err_count, n_tests;
   logic [6:0] sa [4] = '{7'h1a, 7'h10, 7'h36, 7'h37};
   logic [7:0] rt [4] = '{8'h05, 8'h07, 8'h08, 8'h09};
   // Open-drain wire with pull-up
   wire sda = (sda_oe ? sda_out : 1'b1) & sda_m;
   scrb_top u_dut (.CLOCK(clk), .RST(rst), .CE(ce), .SCL(scl), .SDA_IN(sda),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .BUS_ADDR_SEL0(sel0), .BUS_ADDR_SEL1(sel1),
      .FRAME_BOUNDARY(fb), .STANDBY(sb), .UPDATE_HOLD(hold), .SYNC_RUN_N(run_n),
      .SYNC_ROLE_N(role_n), .HORIZONTAL_BINNING(hb), .VERTICAL_BINNING(vb),
      .COMBINED_BINNING(cb), .CONVERSION_WIDTH(cw), .OUTPUT_WIDTH(ow), .LINK_RATE(lr),
      .HORIZONTAL_FLIP(hf), .VERTICAL_FLIP(vf), .GAIN(gain));
   scrb_i2c_mst u_m (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic results();
      if (err_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Address phase shared by writes and random reads
   task automatic ptr(input logic [15:0] a);
      u_m.start();
      u_m.tx({dev, 1'b0}, k);
      chk(16'(k), 16'h0);
      u_m.tx(a[15:8], k);
      u_m.tx(a[7:0], k);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] q[$]);
      ptr(a);
      foreach (q[i]) begin
         u_m.tx(q[i], k);
         chk(16'(k), 16'h0);
      end
      u_m.stop();
   endtask
   // Random read when p is set, else from the current index
   task automatic rd(input logic p, input logic [15:0] a, input logic [7:0] e[$]);
      logic [7:0] d;
      if (p) begin
         ptr(a);
      end
      u_m.start();
      u_m.tx({dev, 1'b1}, k);
      chk(16'(k), 16'h0);
      foreach (e[i]) begin
         u_m.rx(i == e.size() - 1, d);
         chk(16'(d), 16'(e[i]));
      end
      u_m.stop();
   endtask
   // One-cycle frame boundary, then let the copy land
   task automatic pulse();
      fb = 1'b1;
      u_m.w(1);
      fb = 1'b0;
      u_m.w(2);
   endtask
   // Hang guard, about 60000 cycles
   initial begin
      #3000000;
      err_count++;
      results();
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      fb = 1'b0;
      {sel1, sel0} = 2'h0;
      dev = 7'h1a;
      err_count = 0;
      n_tests = 0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk({1'b0, sb, hold, run_n, role_n, hb, vb, cb, cw, ow, lr}, 16'h5034);
      chk(16'({hf, vf, gain}), 16'h0);
      rd(1'b1, ADDR_STANDBY, '{8'h01, 8'h00});
      rd(1'b0, 16'h0, '{8'h01, 8'h00});
      rd(1'b1, ADDR_FLIP, '{8'h00, 8'h01, 8'h01, 8'h04});
      // Every strap setting, then a foreign address
      foreach (sa[i]) begin
         {sel1, sel0} = 2'(i);
         dev = sa[i];
         wr(SPACE_TOP, '{8'h5a + 8'(i)});
         rd(1'b1, SPACE_TOP, '{8'h5a + 8'(i)});
      end
      u_m.start();
      u_m.tx({7'h55, 1'b0}, k);
      chk(16'(k), 16'h1);
      u_m.stop();
      wr(16'h30ff, '{8'ha5, 8'h3c});
      rd(1'b1, 16'h30ff, '{8'ha5, 8'h3c});
      // Standby class waits for release
      wr(ADDR_SYNC_ROLE, '{8'h01});
      wr(ADDR_HBIN, '{8'h01, 8'h01, 8'h01});
      wr(ADDR_CONV_W, '{8'h00, 8'h00});
      chk(16'({role_n, hb, vb, cb, cw, ow}), 16'h03);
      foreach (rt[i]) begin
         wr(ADDR_RATE, '{rt[i]});
         wr(ADDR_STANDBY, '{8'h00});
         chk(16'(sb), 16'h0);
         chk(16'(lr), 16'(rt[i]));
         wr(ADDR_STANDBY, '{8'h01});
      end
      chk(16'({role_n, hb, vb, cb, cw, ow}), 16'he8);
      wr(ADDR_SYNC_RUN, '{8'h00});
      chk(16'(run_n), 16'h0);
      // Frame class, then held, then released
      wr(ADDR_FLIP, '{8'h02});
      chk(16'({vf, hf}), 16'h0);
      pulse();
      chk(16'({vf, hf}), 16'h2);
      wr(ADDR_HOLD, '{8'h01});
      chk(16'(hold), 16'h1);
      wr(ADDR_FLIP, '{8'h01});
      pulse();
      chk(16'({vf, hf}), 16'h2);
      wr(ADDR_HOLD, '{8'h00});
      pulse();
      chk(16'({vf, hf}), 16'h1);
      // Gain lags one more frame
      wr(ADDR_GAIN_LO, '{8'h2a, 8'h01});
      // A boundary seen with the enable low must be swallowed, else gain lands early
      ce = 1'b0;
      pulse();
      ce = 1'b1;
      pulse();
      chk(16'(gain), 16'h0);
      pulse();
      chk(16'(gain), 16'h12a);
      results();
   end
endmodule
